// *** verilog/vtc_ctrl.sv ***
`timescale 1ns/1ps
// Voltage/temperature converter control and status
module vtc_ctrl (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [31:0] i_addr,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [15:0] i_wdata,
    output logic      [15:0] o_rdata,
    input  wire logic        i_core_pd,
    input  wire logic        i_mod_bit,
    output logic      [2:0]  o_src_sel,
    output logic             o_atten_en,
    output logic             o_chop_en,
    output logic             o_ground_switch_pin_direct,
    output logic             o_ground_switch_pin_resistor
);
    import vtc_pkg::*;

    logic [7:0]  adc_mode_reg_r, adc_config_reg_r, high_voltage_config_reg_r;
    logic [15:0] adc_filter_reg_r, voltage_result_reg_r, temperature_result_reg_r;
    logic        cal_r, terr_r, verr_r, trdy_r, vrdy_r;
    logic        cal_busy_r;
    logic [1:0]  settle_r;
    logic [11:0] div_r;
    logic        mod_ce;
    logic        mod_s1_r, mod_s2_r, mod_s3_r, mod_bit_r;
    logic        res_valid;
    logic signed [17:0] res_value;
    logic        wr_mode, wr_cfg, wr_hv, wr_flt;
    logic        rd_volt, rd_temp, rd_cur;
    logic        src_change, deliver, cal_done;
    logic        is_volt, out_rng;
    logic        v_store, t_store;
    logic [15:0] res_sat;
    logic [15:0] status;
    vtc_src_t    src;

    // Source field decode, unused code falls back to battery voltage
    function automatic vtc_src_t src_of(input logic [1:0] code);
        unique case (code)
            2'h0:    src_of = SRC_VBAT;
            2'h1:    src_of = SRC_EXT_TEMP;
            2'h2:    src_of = SRC_CHIP_TEMP;
            default: src_of = SRC_VBAT;
        endcase
    endfunction

    // Address match with strobe
    function automatic logic hit(input logic strobe, input logic [31:0] a, input logic [31:0] ref_a);
        hit = strobe && (a == ref_a);
    endfunction

    // Register strobes; status address has no write decode
    assign wr_mode = hit(i_wr, i_addr, ADDR_MODE);
    assign wr_cfg  = hit(i_wr, i_addr, ADDR_CONFIG);
    assign wr_hv   = hit(i_wr, i_addr, ADDR_HVCFG);
    assign wr_flt  = hit(i_wr, i_addr, ADDR_FILTER);
    assign rd_volt = hit(i_rd, i_addr, ADDR_VOLT);
    assign rd_temp = hit(i_rd, i_addr, ADDR_TEMP);
    assign rd_cur  = hit(i_rd, i_addr, ADDR_CURRENT);

    assign src        = src_of(adc_config_reg_r[CFG_SRC_LSB +: 2]);
    assign src_change = wr_cfg && (src_of(i_wdata[CFG_SRC_LSB +: 2]) != src);

    // Modulator sample enable from divider
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            div_r <= '0;
        end else if (div_r == MOD_DIV_LAST) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 12'h1;
        end
    end
    assign mod_ce = (div_r == MOD_DIV_LAST);

    // Modulator bit synchroniser, accepted once stages two and three agree
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mod_s1_r  <= 1'b0;
            mod_s2_r  <= 1'b0;
            mod_s3_r  <= 1'b0;
            mod_bit_r <= 1'b0;
        end else begin
            mod_s1_r <= i_mod_bit;
            mod_s2_r <= mod_s1_r;
            mod_s3_r <= mod_s2_r;
            if (mod_s2_r == mod_s3_r) begin
                mod_bit_r <= mod_s3_r;
            end
        end
    end

    // Decimation filter
    vtc_sinc3 u_sinc3 (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_ce      (mod_ce),
        .i_bit     (mod_bit_r),
        .i_dec_log (adc_filter_reg_r[FLT_DEC_LSB +: 4]),
        .o_valid   (res_valid),
        .o_value   (res_value)
    );

    // Control registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            adc_mode_reg_r            <= RST_8;
            adc_config_reg_r          <= RST_8;
            high_voltage_config_reg_r <= RST_8;
            adc_filter_reg_r          <= RST_16;
        end else begin
            if (wr_mode) begin
                adc_mode_reg_r <= i_wdata[7:0];
            end
            if (wr_cfg) begin
                adc_config_reg_r <= i_wdata[7:0];
            end
            if (wr_hv) begin
                high_voltage_config_reg_r <= i_wdata[7:0];
            end
            if (wr_flt) begin
                adc_filter_reg_r <= i_wdata;
            end
        end
    end

    // Analog-side controls from flops
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_src_sel         <= 3'h1;
            o_atten_en        <= 1'b0;
            o_chop_en         <= 1'b0;
            o_ground_switch_pin_direct   <= 1'b0;
            o_ground_switch_pin_resistor <= 1'b0;
        end else begin
            o_src_sel <= 3'h1 << src;
            o_atten_en <= high_voltage_config_reg_r[HV_ATTEN];
            o_chop_en  <= adc_config_reg_r[CFG_CHOP];
            o_ground_switch_pin_direct   <= adc_config_reg_r[CFG_GND_EN] &&
                                 !adc_mode_reg_r[MODE_GND_RES];
            o_ground_switch_pin_resistor <= adc_config_reg_r[CFG_GND_EN] &&
                                 adc_mode_reg_r[MODE_GND_RES];
        end
    end

    // Calibration sequencing, ends with the next conversion result
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cal_busy_r <= 1'b0;
        end else if (wr_mode) begin
            cal_busy_r <= (i_wdata[MODE_FN_LSB +: 3] == MODE_FN_CAL);
        end else if (cal_done) begin
            cal_busy_r <= 1'b0;
        end
    end
    assign cal_done = cal_busy_r && res_valid;

    // Settling: discard conversions after a source switch
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            settle_r <= SETTLE_NOCHOP;
        end else if (src_change) begin
            settle_r <= i_wdata[CFG_CHOP] ? SETTLE_CHOP : SETTLE_NOCHOP;
        end else if (res_valid && (settle_r != 2'h0)) begin
            settle_r <= settle_r - 2'h1;
        end
    end

    // Result classification and saturation
    assign deliver = res_valid && (settle_r == 2'h0) && !cal_busy_r && !src_change;
    assign is_volt = (src == SRC_VBAT);
    assign out_rng = (res_value > MAX_18) || (res_value < MIN_18);
    assign res_sat = (res_value > MAX_18) ? FS_POS :
                     (res_value < MIN_18) ? FS_NEG : res_value[15:0];
    assign v_store = deliver && is_volt && (!vrdy_r || i_core_pd);
    assign t_store = deliver && !is_volt && (!trdy_r || i_core_pd);

    // Result registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            voltage_result_reg_r     <= RST_16;
            temperature_result_reg_r <= RST_16;
        end else begin
            if (v_store) begin
                voltage_result_reg_r <= res_sat;
            end
            if (t_store) begin
                temperature_result_reg_r <= res_sat;
            end
        end
    end

    // Status flags; hardware set wins over clear
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cal_r  <= 1'b0;
            terr_r <= 1'b0;
            verr_r <= 1'b0;
            trdy_r <= 1'b0;
            vrdy_r <= 1'b0;
        end else begin
            if (cal_done) begin
                cal_r <= 1'b1;
            end else if (wr_mode) begin
                cal_r <= 1'b0;
            end
            if (deliver && !is_volt && out_rng) begin
                terr_r <= 1'b1;
            end else if (t_store) begin
                terr_r <= 1'b0;
            end
            if (deliver && is_volt && out_rng) begin
                verr_r <= 1'b1;
            end else if (v_store) begin
                verr_r <= 1'b0;
            end
            if (v_store || cal_done) begin
                vrdy_r <= 1'b1;
            end else if (rd_volt || rd_cur) begin
                vrdy_r <= 1'b0;
            end
            if (t_store || cal_done) begin
                trdy_r <= 1'b1;
            end else if (rd_temp || rd_cur) begin
                trdy_r <= 1'b0;
            end
        end
    end

    // Status word; writes to it have no decode
    always_comb begin
        status          = RST_16;
        status[ST_CAL]  = cal_r;
        status[ST_TERR] = terr_r;
        status[ST_VERR] = verr_r;
        status[ST_TRDY] = trdy_r;
        status[ST_VRDY] = vrdy_r;
    end

    // Read data, registered on the read strobe
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= RST_16;
        end else if (i_rd) begin
            unique case (i_addr)
                ADDR_STATUS: o_rdata <= status;
                ADDR_MODE:   o_rdata <= {8'h00, adc_mode_reg_r};
                ADDR_CONFIG: o_rdata <= {8'h00, adc_config_reg_r};
                ADDR_HVCFG:  o_rdata <= {8'h00, high_voltage_config_reg_r};
                ADDR_FILTER: o_rdata <= adc_filter_reg_r;
                ADDR_VOLT:   o_rdata <= voltage_result_reg_r;
                ADDR_TEMP:   o_rdata <= temperature_result_reg_r;
                default:     o_rdata <= RST_16;
            endcase
        end
    end

endmodule

// *** verilog/vtc_pkg.sv ***
// Behaviour
// - Exactly one of battery voltage, external or on-chip temperature feeds the converter.
// - Sinc3 decimation yields 16-bit results at a rate from 4 Hz to 8 kHz.
// - Attenuator on/off comes only from bit 7 of high-voltage config; software sets it.
// - After a source change, results are withheld for three conversion cycles, two when the new config sets chop (bit 3).
// - Ground switch floats unless config bit 7; mode bit 6 picks direct or resistor.
// - Status bit 15 sets at calibration end, clears on a mode register write in any other cycle.
// - Status bit 14 sets on an out-of-range temperature conversion that is delivered (not while settling or calibrating).
// - Range errors store positive or negative full scale.
// - Bit 14 clears when an in-range temperature result is stored.
// - Bit 13 sets on voltage range error, clears on in-range voltage store.
// - Status bit 1 sets on voltage store or calibration end; voltage/current reads clear it.
// - Running core: no overwrite until ready cleared; powered-down core: always store newest.
package vtc_pkg;

    // Register addresses
    localparam logic [31:0] ADDR_STATUS  = 32'hFFFF_0500;
    localparam logic [31:0] ADDR_MODE    = 32'hFFFF_0508;
    localparam logic [31:0] ADDR_CONFIG  = 32'hFFFF_0510;
    localparam logic [31:0] ADDR_FILTER  = 32'hFFFF_0514;
    localparam logic [31:0] ADDR_VOLT    = 32'hFFFF_0518;
    localparam logic [31:0] ADDR_CURRENT = 32'hFFFF_051C;
    localparam logic [31:0] ADDR_TEMP    = 32'hFFFF_0520;
    localparam logic [31:0] ADDR_HVCFG   = 32'hFFFF_0524;

    // Reset values
    localparam logic [15:0] RST_16 = 16'h0000;
    localparam logic [7:0]  RST_8  = 8'h00;

    // Status bit positions
    localparam int ST_CAL  = 15;
    localparam int ST_TERR = 14;
    localparam int ST_VERR = 13;
    localparam int ST_TRDY = 2;
    localparam int ST_VRDY = 1;

    // Control field positions
    localparam int CFG_GND_EN   = 7;
    localparam int CFG_CHOP     = 3;
    localparam int CFG_SRC_LSB  = 0;
    localparam int MODE_GND_RES = 6;
    localparam int MODE_FN_LSB  = 0;
    localparam int HV_ATTEN     = 7;
    localparam int FLT_DEC_LSB  = 0;
    localparam logic [2:0] MODE_FN_CAL = 3'h4;

    // Decimation: log2 of factor, 2 gives 8 kHz, 13 gives about 4 Hz
    localparam logic [3:0] DEC_LOG_MIN = 4'h2;
    localparam logic [3:0] DEC_LOG_MAX = 4'hD;
    localparam int         ACC_W       = 40;
    localparam int         OUT_LOG     = 16;

    // Full-scale codes
    localparam logic [15:0]        FS_POS  = 16'h7FFF;
    localparam logic [15:0]        FS_NEG  = 16'h8000;
    localparam logic signed [17:0] MID_18  = 18'sh08000;
    localparam logic signed [17:0] MAX_18  = 18'sh07FFF;
    localparam logic signed [17:0] MIN_18  = -18'sh08000;

    // Settling counts in conversions
    localparam logic [1:0] SETTLE_NOCHOP = 2'h3;
    localparam logic [1:0] SETTLE_CHOP   = 2'h2;

    // Modulator sample rate derived from system clock
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int MOD_RATE_HZ = 32_000;
    localparam int MOD_DIV = SYS_CLK_HZ / MOD_RATE_HZ;
    localparam logic [11:0] MOD_DIV_LAST = 12'(MOD_DIV - 1);

    // Converter input source
    typedef enum logic [1:0] {SRC_VBAT, SRC_EXT_TEMP, SRC_CHIP_TEMP} vtc_src_t;

endpackage

// *** verilog/vtc_sinc3.sv ***
`timescale 1ns/1ps
// Sinc3 decimator with power-of-two factor
module vtc_sinc3 (
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    input  wire logic               i_ce,
    input  wire logic               i_bit,
    input  wire logic [3:0]         i_dec_log,
    output logic                    o_valid,
    output logic signed [17:0]      o_value
);
    import vtc_pkg::*;

    logic [ACC_W-1:0] int1_r, int2_r, int3_r;
    logic [ACC_W-1:0] dly1_r, dly2_r, dly3_r;
    logic [12:0]      cnt_r;
    logic [3:0]       dec_log;
    logic [12:0]      cnt_last;
    logic [ACC_W-1:0] comb1, comb2, comb3;
    logic [ACC_W-1:0] scaled;
    logic [5:0]       grow;

    // Clamp factor to the supported span
    assign dec_log  = (i_dec_log < DEC_LOG_MIN) ? DEC_LOG_MIN :
                      (i_dec_log > DEC_LOG_MAX) ? DEC_LOG_MAX : i_dec_log;
    assign cnt_last = 13'((14'h1 << dec_log) - 14'h1);
    assign comb1    = int3_r - dly1_r;
    assign comb2    = comb1 - dly2_r;
    assign comb3    = comb2 - dly3_r;
    assign grow     = 6'(3 * dec_log);
    // Bring D^3 full scale to 2^16
    assign scaled   = (grow >= 6'(OUT_LOG)) ? (comb3 >> (grow - 6'(OUT_LOG)))
                                            : (comb3 << (6'(OUT_LOG) - grow));

    // Integrators at modulator rate
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            int1_r <= '0;
            int2_r <= '0;
            int3_r <= '0;
        end else if (i_ce) begin
            int1_r <= int1_r + ACC_W'(i_bit);
            int2_r <= int2_r + int1_r;
            int3_r <= int3_r + int2_r;
        end
    end

    // Decimation counter and combs at output rate
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r   <= '0;
            dly1_r  <= '0;
            dly2_r  <= '0;
            dly3_r  <= '0;
            o_valid <= 1'b0;
            o_value <= '0;
        end else begin
            o_valid <= 1'b0;
            if (i_ce) begin
                if (cnt_r >= cnt_last) begin
                    cnt_r   <= '0;
                    dly1_r  <= int3_r;
                    dly2_r  <= comb1;
                    dly3_r  <= comb2;
                    o_valid <= 1'b1;
                    o_value <= $signed(scaled[17:0]) - MID_18;
                end else begin
                    cnt_r <= cnt_r + 13'h1;
                end
            end
        end
    end

endmodule

// *** tb/vtc_ctrl_monitor.sv ***
`timescale 1ns/1ps
// Port-level checks of the converter control block
module vtc_ctrl_monitor
    import vtc_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic [31:0] i_addr,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] i_wdata,
    input wire logic [15:0] o_rdata,
    input wire logic        i_core_pd,
    input wire logic        i_mod_bit,
    input wire logic [2:0]  o_src_sel,
    input wire logic        o_atten_en,
    input wire logic        o_chop_en,
    input wire logic        o_ground_switch_pin_direct,
    input wire logic        o_ground_switch_pin_resistor
);
    logic       cfg_w;
    logic [2:0] src_dec;
    logic       gnd_en_r;
    logic       gnd_res_r;

    // Config write strobe and expected source decode
    assign cfg_w   = i_wr && i_addr == ADDR_CONFIG;
    assign src_dec = i_wdata[1:0] == 2'h1 ? 3'h2 : i_wdata[1:0] == 2'h2 ? 3'h4 : 3'h1;

    // Shadow of the ground switch control bits
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gnd_en_r  <= 1'b0;
            gnd_res_r <= 1'b0;
        end else begin
            if (cfg_w) gnd_en_r <= i_wdata[CFG_GND_EN];
            if (i_wr && i_addr == ADDR_MODE) gnd_res_r <= i_wdata[MODE_GND_RES];
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_src_onehot; $onehot(o_src_sel); endproperty
    a_src_onehot: assert property (p_src_onehot) else $error("source not one-hot");
    property p_src_write; cfg_w |-> ##2 o_src_sel == $past(src_dec, 2); endproperty
    a_src_write: assert property (p_src_write) else $error("source decode wrong");
    property p_atten; i_wr && i_addr == ADDR_HVCFG |-> ##2 o_atten_en == $past(i_wdata[HV_ATTEN], 2); endproperty
    a_atten: assert property (p_atten) else $error("attenuator not from hv bit");
    property p_atten_only; $changed(o_atten_en) |-> $past(i_wr && i_addr == ADDR_HVCFG, 2); endproperty
    a_atten_only: assert property (p_atten_only) else $error("attenuator moved alone");
    property p_chop; cfg_w |-> ##2 o_chop_en == $past(i_wdata[CFG_CHOP], 2); endproperty
    a_chop: assert property (p_chop) else $error("chop enable wrong");
    property p_gnd_dir; o_ground_switch_pin_direct == $past(gnd_en_r && !gnd_res_r); endproperty
    a_gnd_dir: assert property (p_gnd_dir) else $error("direct ground wrong");
    property p_gnd_res; o_ground_switch_pin_resistor == $past(gnd_en_r && gnd_res_r); endproperty
    a_gnd_res: assert property (p_gnd_res) else $error("resistor ground wrong");
    property p_cal_clr;
        i_wr && i_addr == ADDR_MODE ##[1:4] i_rd && i_addr == ADDR_STATUS |=> !o_rdata[ST_CAL];
    endproperty
    a_cal_clr: assert property (p_cal_clr) else $error("cal flag kept after mode write");
endmodule

bind vtc_ctrl vtc_ctrl_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr),
    .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_core_pd(i_core_pd), .i_mod_bit(i_mod_bit),
    .o_src_sel(o_src_sel), .o_atten_en(o_atten_en), .o_chop_en(o_chop_en),
    .o_ground_switch_pin_direct(o_ground_switch_pin_direct), .o_ground_switch_pin_resistor(o_ground_switch_pin_resistor));

// *** tb/vtc_mod_model.sv ***
`timescale 1ns/1ps
// Bitstream source standing in for the analog modulator
module vtc_mod_model (
    input  wire logic       i_clk,
    input  wire logic [1:0] i_level,
    output logic            o_bit
);
    logic tog_r = 1'b0;

    // Toggle pattern for a mid-scale input
    always_ff @(posedge i_clk) tog_r <= ~tog_r;

    // 0 full negative, 1 mid-scale, 2 full positive
    assign o_bit = i_level == 2'h2 ? 1'b1 : i_level == 2'h1 ? tog_r : 1'b0;
endmodule

// *** tb/voltage_temp_adc_control_test.sv ***
`timescale 1ns/1ps
module voltage_temp_adc_control_test;
    import vtc_pkg::*;
    localparam int LIMIT = 95000;  // Scenarios need about 88k cycles
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [31:0] i_addr = '0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [15:0] i_wdata = '0;
    logic        i_core_pd = 1'b0;
    logic [1:0]  level = 2'h1;
    logic        mod_bit;
    logic [15:0] o_rdata;
    logic [2:0]  o_src_sel;
    logic        o_atten_en;
    logic        o_chop_en;
    logic        o_ground_switch_pin_direct;
    logic        o_ground_switch_pin_resistor;
    logic [31:0] q[$];
    logic [31:0] ent;
    logic [15:0] last = '0;
    logic        rd_seen = 1'b0;
    logic [31:0] rnd = 32'h1B73;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cyc = 0;

    vtc_mod_model u_mod (.i_clk(i_clk), .i_level(level), .o_bit(mod_bit));
    vtc_ctrl uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
        .i_wdata(i_wdata), .o_rdata(o_rdata), .i_core_pd(i_core_pd), .i_mod_bit(mod_bit),
        .o_src_sel(o_src_sel), .o_atten_en(o_atten_en), .o_chop_en(o_chop_en),
        .o_ground_switch_pin_direct(o_ground_switch_pin_direct), .o_ground_switch_pin_resistor(o_ground_switch_pin_resistor));

    // Free-running system clock
    initial begin
        forever #5 i_clk = ~i_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Register write; returns once the control outputs have followed
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(negedge i_clk);
        i_addr = a;
        i_wdata = d;
        i_wr = 1'b1;
        @(negedge i_clk);
        i_wr = 1'b0;
        repeat (2) @(negedge i_clk);
    endtask

    // Register read; expected value and bit mask go to the watcher
    task automatic rd(input logic [31:0] a, input logic [15:0] e, input logic [15:0] m);
        @(negedge i_clk);
        i_addr = a;
        i_rd = 1'b1;
        q.push_back({m, e});
        @(negedge i_clk);
        i_rd = 1'b0;
        @(negedge i_clk);
    endtask

    // Status polling until a flag rises, bounded
    task automatic poll(input int b);
        last = '0;
        for (int i = 0; i < 40000 && last[b] !== 1'b1; i++) rd(ADDR_STATUS, 16'h0000, 16'h0000);
    endtask

    // Watcher: read data is taken the cycle after the strobe
    always @(posedge i_clk) begin
        if (rd_seen) begin
            last = o_rdata;
            ent = q.pop_front();
            chk("rdata", o_rdata & ent[31:16], ent[15:0] & ent[31:16]);
        end
        rd_seen <= i_rd;
    end

    // Hang guard
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        repeat (20) @(negedge i_clk);
        i_rst = 1'b0;
        chk("src", {13'h0, o_src_sel}, 16'h0001);
        chk("gnd", {14'h0, o_ground_switch_pin_direct, o_ground_switch_pin_resistor}, 16'h0000);
        rd(ADDR_STATUS, RST_16, 16'hFFFF);
        $display("reset test done");
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_CONFIG, 16'(k));
            chk("src", {13'h0, o_src_sel}, k == 1 ? 16'h0002 : k == 2 ? 16'h0004 : 16'h0001);
        end
        $display("source test done");
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_MODE, {9'h0, k[1], 6'h0});
            wr(ADDR_CONFIG, {8'h0, k[0], 7'h08});
            chk("gnd", {14'h0, o_ground_switch_pin_direct, o_ground_switch_pin_resistor}, {14'h0, k[0] & ~k[1], k[0] & k[1]});
            chk("chop", {15'h0, o_chop_en}, 16'h0001);
        end
        $display("ground switch test done");
        for (int k = 0; k < 6; k++) begin
            rnd = lfsr(rnd);
            wr(ADDR_HVCFG, rnd[15:0]);
            chk("atten", {15'h0, o_atten_en}, {15'h0, rnd[HV_ATTEN]});
        end
        $display("attenuator test done");
        wr(ADDR_STATUS, 16'hFFFF);
        rd(ADDR_STATUS, RST_16, 16'hFFFF);
        rd(32'hFFFF_0540, 16'h0000, 16'hFFFF);
        $display("read-only test done");
        level = 2'h2;
        wr(ADDR_FILTER, 16'h0002);
        wr(ADDR_CONFIG, 16'h0000);
        poll(ST_VERR);
        rd(ADDR_STATUS, 16'h2000, 16'h2000);
        rd(ADDR_VOLT, FS_POS, 16'hFFFF);
        $display("over-range test done");
        wr(ADDR_MODE, {13'h0, MODE_FN_CAL});
        rd(ADDR_STATUS, 16'h0000, 16'h8000);
        poll(ST_CAL);
        rd(ADDR_STATUS, 16'h8006, 16'h8006);
        rd(ADDR_VOLT, FS_POS, 16'hFFFF);
        rd(ADDR_STATUS, 16'h0004, 16'h0006);
        rd(ADDR_CURRENT, 16'h0000, 16'hFFFF);
        rd(ADDR_STATUS, 16'h0000, 16'h0006);
        wr(ADDR_MODE, 16'h0000);
        rd(ADDR_STATUS, 16'h0000, 16'h8000);
        $display("calibration test done");
        // Next full-scale result is stored, then a lower one must be refused
        repeat (13000) @(negedge i_clk);
        level = 2'h0;
        repeat (12700) @(negedge i_clk);
        rd(ADDR_STATUS, 16'h2002, 16'h2002);
        rd(ADDR_VOLT, FS_POS, 16'hFFFF);
        $display("no-overwrite test done");
        end_sim();
    end
endmodule
